// [inc/qtu_defines.vh]
// Offsets, field positions, reset values and codes for the quad timer unit
`ifndef QTU_DEFINES_VH
`define QTU_DEFINES_VH
// Register byte offsets
`define QTU_MODE_OFS 8'h00
`define QTU_POL_OFS 8'h04
`define QTU_IEN_OFS 8'h08
`define QTU_PEND_OFS 8'h0C
`define QTU_PRSC_OFS 8'h10
`define QTU_CNT_OFS 8'h20
`define QTU_PER_OFS 8'h30
`define QTU_DTY_OFS 8'h40
// Register stride for per-subsystem registers
`define QTU_SUB_STRIDE 8'h04
// Mode field codes
`define QTU_MODE_LP 2'b00
`define QTU_MODE_PWM8 2'b01
// Mode register layout per subsystem nibble
`define QTU_MODE_BITS 4
`define QTU_MODE_FLD 2
// Pending flag positions within a subsystem nibble
`define QTU_FLAG_A 0
`define QTU_FLAG_B 1
`define QTU_FLAG_C 2
`define QTU_FLAG_D 3
// Reset values
`define QTU_RST_WORD 32'h0000_0000
`define QTU_RST_BYTE 8'h00
// Bus response codes
`define QTU_RESP_OKAY 2'b00
`define QTU_RESP_DECERR 2'b11
`endif

// [src/qtu_top.v]
// Quad timer unit with dual 8-bit PWM subsystems behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "qtu_defines.vh"

module qtu_top #(
  parameter SUBS = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timer pins and interrupt requests
  output reg [2*SUBS-1:0] timer_io_pin,
  output reg [SUBS-1:0] irq
);

  // Software-visible state
  reg [31:0] mode_reg;
  reg [31:0] pin_control_reg;
  reg [31:0] int_enable;
  reg [31:0] pending;
  reg [31:0] prescale_value;
  reg [15:0] period_compare_reg [0:SUBS-1];
  reg [15:0] duty_compare_reg [0:SUBS-1];

  // Captured bus write
  reg aw_held;
  reg w_held;
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;

  // Cross-module state views
  wire [16*SUBS-1:0] cnt_view;
  wire [4*SUBS-1:0] events;
  wire [SUBS-1:0] tick;
  wire wr_fire;
  wire [31:0] wmask;
  wire [31:0] wval;

  // Write happens once both halves are held and no response pends
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wval = wr_data & wmask;

  // Address decode helpers
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `QTU_MODE_OFS) || (a == `QTU_POL_OFS) || (a == `QTU_IEN_OFS) ||
                  (a == `QTU_PEND_OFS) || (a == `QTU_PRSC_OFS) ||
                  ((a >= `QTU_CNT_OFS) && (a < `QTU_DTY_OFS + `QTU_SUB_STRIDE * SUBS) && (a[1:0] == 2'b00) &&
                   (a[3:2] < SUBS));
    end
  endfunction

  // AXI4-Lite write channel handling
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QTU_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= `QTU_RST_BYTE;
      wr_data <= `QTU_RST_WORD;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? `QTU_RESP_OKAY : `QTU_RESP_DECERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read data multiplexer
  reg [31:0] rd_mux;
  integer ri;
  always @*
  begin
    rd_mux = `QTU_RST_WORD;
    case (s_axi_araddr)
      `QTU_MODE_OFS: rd_mux = mode_reg;
      `QTU_POL_OFS: rd_mux = pin_control_reg;
      `QTU_IEN_OFS: rd_mux = int_enable;
      `QTU_PEND_OFS: rd_mux = pending;
      `QTU_PRSC_OFS: rd_mux = prescale_value;
      default:
      begin
        for (ri = 0; ri < SUBS; ri = ri + 1)
        begin
          if (s_axi_araddr == `QTU_CNT_OFS + `QTU_SUB_STRIDE * ri)
            rd_mux = {16'h0000, cnt_view[16*ri +: 16]};
          if (s_axi_araddr == `QTU_PER_OFS + `QTU_SUB_STRIDE * ri)
            rd_mux = {16'h0000, period_compare_reg[ri]};
          if (s_axi_araddr == `QTU_DTY_OFS + `QTU_SUB_STRIDE * ri)
            rd_mux = {16'h0000, duty_compare_reg[ri]};
        end
      end
    endcase
  end

  // AXI4-Lite read channel, one-cycle answer
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `QTU_RST_WORD;
      s_axi_rresp <= `QTU_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `QTU_RESP_OKAY : `QTU_RESP_DECERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control registers and pending flags
  integer si;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_reg <= `QTU_RST_WORD;
      pin_control_reg <= `QTU_RST_WORD;
      int_enable <= `QTU_RST_WORD;
      pending <= `QTU_RST_WORD;
      prescale_value <= `QTU_RST_WORD;
      for (si = 0; si < SUBS; si = si + 1)
      begin
        period_compare_reg[si] <= 16'h0000;
        duty_compare_reg[si] <= 16'h0000;
      end
    end
    else
    begin
      if (wr_fire && wr_addr == `QTU_MODE_OFS)
        mode_reg <= (mode_reg & ~wmask) | wval;
      if (wr_fire && wr_addr == `QTU_POL_OFS)
        pin_control_reg <= (pin_control_reg & ~wmask) | wval;
      if (wr_fire && wr_addr == `QTU_IEN_OFS)
        int_enable <= (int_enable & ~wmask) | wval;
      if (wr_fire && wr_addr == `QTU_PRSC_OFS)
        prescale_value <= (prescale_value & ~wmask) | wval;
      if (wr_fire && wr_addr == `QTU_PEND_OFS)
        pending <= (pending & ~wval) | {{(32-4*SUBS){1'b0}}, events};
      else
        pending <= pending | {{(32-4*SUBS){1'b0}}, events};
      for (si = 0; si < SUBS; si = si + 1)
      begin
        // compare writes blocked in low power
        if (mode_reg[`QTU_MODE_BITS*si+2 +: `QTU_MODE_FLD] != `QTU_MODE_LP)
        begin
          if (wr_fire && wr_addr == `QTU_PER_OFS + `QTU_SUB_STRIDE * si)
            period_compare_reg[si] <= (period_compare_reg[si] & ~wmask[15:0]) | wval[15:0];
          if (wr_fire && wr_addr == `QTU_DTY_OFS + `QTU_SUB_STRIDE * si)
            duty_compare_reg[si] <= (duty_compare_reg[si] & ~wmask[15:0]) | wval[15:0];
        end
      end
    end
  end

  // Interrupt requests, one per subsystem
  integer ii;
  always @(posedge clk)
  begin
    if (!reset_n)
      irq <= {SUBS{1'b0}};
    else
      for (ii = 0; ii < SUBS; ii = ii + 1)
        irq[ii] <= |(pending[4*ii +: 4] & int_enable[4*ii +: 4]);
  end

  // Per-subsystem prescaler
  // four independent subsystems
  genvar gs;
  generate
    for (gs = 0; gs < SUBS; gs = gs + 1)
    begin : g_sub
      reg [7:0] pre_cnt;
      wire any_run;
      wire low_power;
      wire [7:0] pre_val;
      assign any_run = mode_reg[`QTU_MODE_BITS*gs] | mode_reg[`QTU_MODE_BITS*gs+1];
      assign low_power = mode_reg[`QTU_MODE_BITS*gs+2 +: `QTU_MODE_FLD] == `QTU_MODE_LP;
      assign pre_val = prescale_value[8*gs +: 8];
      assign tick[gs] = any_run & ~low_power & (pre_cnt == pre_val);
      always @(posedge clk)
      begin
        if (!reset_n)
          pre_cnt <= 8'h00;
        else if (low_power)
          pre_cnt <= pre_cnt;
        else if (!any_run)
          pre_cnt <= 8'h00;
        else if (tick[gs])
          pre_cnt <= 8'h00;
        else
          pre_cnt <= pre_cnt + 8'h01;
      end
    end
  endgenerate

  // Per-channel 8-bit PWM; even channel uses low byte, odd the high byte
  genvar gc;
  generate
    for (gc = 0; gc < 2*SUBS; gc = gc + 1)
    begin : g_chan
      localparam SI = gc / 2;
      localparam HI = gc % 2;
      reg [7:0] cnt;
      reg [7:0] act_per;
      reg [7:0] act_duty;
      reg active;
      reg [7:0] next_cnt;
      reg next_active;
      wire run;
      wire pwm_mode;
      wire low_power;
      wire step;
      wire per_hit;
      wire duty_hit;
      wire cnt_wr;
      wire pol;
      assign run = mode_reg[`QTU_MODE_BITS*SI+HI];
      assign pol = pin_control_reg[gc];
      assign pwm_mode = mode_reg[`QTU_MODE_BITS*SI+2 +: `QTU_MODE_FLD] == `QTU_MODE_PWM8;
      assign low_power = mode_reg[`QTU_MODE_BITS*SI+2 +: `QTU_MODE_FLD] == `QTU_MODE_LP;
      assign step = pwm_mode & run & tick[SI];
      assign per_hit = cnt == act_per;
      assign duty_hit = cnt == act_duty;
      // counter preset only when both stopped
      assign cnt_wr = wr_fire & (wr_addr == `QTU_CNT_OFS + `QTU_SUB_STRIDE * SI) & ~low_power &
                      ~mode_reg[`QTU_MODE_BITS*SI] & ~mode_reg[`QTU_MODE_BITS*SI+1] & wr_strb[HI];
      assign cnt_view[8*gc +: 8] = cnt;
      assign events[4*SI + 2*HI] = step & duty_hit;
      assign events[4*SI + 2*HI + 1] = step & per_hit;

      // Next count and waveform state
      always @*
      begin
        next_cnt = cnt;
        next_active = active;
        if (cnt_wr)
          next_cnt = wr_data[8*HI +: 8];
        else if (step)
        begin
          // preset above period rolls at FF
          if (per_hit)
            next_cnt = 8'h00;
          else
            next_cnt = cnt + 8'h01;
          if (duty_hit && act_duty <= act_per)
            next_active = 1'b0;
          if (cnt == 8'h00 && act_duty != 8'h00)
            next_active = 1'b1;
        end
        if (!(pwm_mode & run))
          next_active = 1'b0;
      end

      // Counter, active compares and pin
      always @(posedge clk)
      begin
        if (!reset_n)
        begin
          cnt <= 8'h00;
          act_per <= 8'h00;
          act_duty <= 8'h00;
          active <= 1'b0;
          timer_io_pin[gc] <= 1'b0;
        end
        else
        begin
          cnt <= next_cnt;
          active <= next_active;
          timer_io_pin[gc] <= pol ^ next_active;
          // load on period match or stop
          if (!run || (step && per_hit))
          begin
            act_per <= period_compare_reg[SI][8*HI +: 8];
            act_duty <= duty_compare_reg[SI][8*HI +: 8];
          end
        end
      end
    end
  endgenerate

endmodule // qtu_top

// [testbench/qtu_pwm_load.sv]
// Load model that tallies high cycles and rising edges on the timer pins
`timescale 1ns/100ps
module qtu_pwm_load (
  // Clock and tally clear
  input wire logic clk,
  input wire logic clr,
  // Observed pins
  input wire logic [7:0] pins,
  // Tallies per pin
  output logic [15:0] hi [8],
  output logic [15:0] rs [8]
);
  logic [7:0] last;
  // Count high samples and low-to-high steps
  always @(posedge clk)
  begin
    last <= pins;
    for (int i = 0; i < 8; i++)
    begin
      hi[i] <= clr ? 16'h0000 : hi[i] + {15'h0000, pins[i]};
      rs[i] <= clr ? 16'h0000 : rs[i] + {15'h0000, pins[i] & ~last[i]};
    end
  end
endmodule // qtu_pwm_load

// [testbench/qtu_top_checker.sv]
// Bus and pin assertions for the quad timer unit
`timescale 1ns/100ps
`include "qtu_defines.vh"
module qtu_top_checker #(
  parameter SUBS = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins and requests
  input wire [2*SUBS-1:0] timer_io_pin,
  input wire [SUBS-1:0] irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Outputs at rest after reset
  AST_RESET_OUT: assert property ($rose(reset_n) |-> timer_io_pin == 0 && irq == 0 && s_axi_awready
    && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not at rest");
  AST_B_AFTER_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response open");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_B_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == `QTU_RESP_OKAY
    || s_axi_bresp == `QTU_RESP_DECERR) else $error("bad write code");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while open");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_DEC_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `QTU_RESP_DECERR |-> s_axi_rdata == 0)
    else $error("unmapped read data not zero");
  // Main scenarios seen
  COV_DEC: cover property (s_axi_rvalid && s_axi_rresp == `QTU_RESP_DECERR);
  COV_PIN: cover property ($rose(timer_io_pin[1]));
  COV_IRQ: cover property ($rose(irq[0]));
endmodule // qtu_top_checker
bind qtu_top qtu_top_checker #(.SUBS(SUBS)) u_chk (.clk(clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_io_pin(timer_io_pin), .irq(irq));

// [testbench/qtu_top_tb_top.sv]
// Self-checking bench for the quad timer unit in dual 8-bit mode
`timescale 1ns/100ps
`include "qtu_defines.vh"
module qtu_top_tb_top;
  typedef struct packed {logic [7:0] s, p0, d0, p1, d1; logic [15:0] h0, r0, h1, r1;} qtu_row_t;
  logic clk = 1'b0, reset_n = 1'b0, clr = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rdat;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] timer_io_pin;
  wire [3:0] irq;
  logic [15:0] hi [8];
  logic [15:0] rs [8];
  logic [1:0] rsp;
  int errors = 0, checked = 0;
  // Prescale, periods, duties; high and rise tallies over 240 cycles
  qtu_row_t rows [4] = '{
    '{8'h00, 8'h03, 8'h01, 8'h04, 8'h02, 16'h003C, 16'h003C, 16'h0060, 16'h0030},
    '{8'h01, 8'h03, 8'h03, 8'h02, 8'h05, 16'h00B4, 16'h001E, 16'h00F0, 16'h0000},
    '{8'h02, 8'h04, 8'h00, 8'h01, 8'h01, 16'h0000, 16'h0000, 16'h0078, 16'h0028},
    '{8'h03, 8'h05, 8'h05, 8'h00, 8'h01, 16'h00C8, 16'h000A, 16'h00F0, 16'h0000}};
  // Response channels always ready, full words only
  qtu_top uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .timer_io_pin(timer_io_pin), .irq(irq));
  qtu_pwm_load u_load (.clk(clk), .clr(clr), .pins(timer_io_pin), .hi(hi), .rs(rs));
  always #5 clk = ~clk;
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bus write; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        return;
      end
    end
    check("bvalid", 32'h0000_0001, 32'h0000_0000);
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        return;
      end
    end
    check("rvalid", 32'h0000_0001, 32'h0000_0000);
  endtask
  // Restart the tallies
  task automatic tally_clear;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #100000;
    errors++;
    print_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`QTU_MODE_OFS);
    check("mode reset", `QTU_RST_WORD, rdat);
    foreach (rows[i])
    begin
      wr(`QTU_MODE_OFS, 32'h0000_0004);
      wr(`QTU_CNT_OFS, 32'h0000_0000);
      wr(`QTU_PRSC_OFS, {24'h00_0000, rows[i].s});
      wr(`QTU_PER_OFS, {16'h0000, rows[i].p1, rows[i].p0});
      wr(`QTU_DTY_OFS, {16'h0000, rows[i].d1, rows[i].d0});
      wr(`QTU_MODE_OFS, 32'h0000_0007);
      repeat (40) @(posedge clk);
      tally_clear();
      repeat (240) @(posedge clk);
      #1;
      check("low pin high", rows[i].h0, hi[0]);
      check("low pin rises", rows[i].r0, rs[0]);
      check("high pin high", rows[i].h1, hi[1]);
      check("high pin rises", rows[i].r1, rs[1]);
      @(posedge clk);
    end
    rd(`QTU_PEND_OFS);
    check("pending", 32'h0000_000F, {28'h000_0000, rdat[3:0]});
    wr(`QTU_IEN_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("irq set", 32'h0000_0001, {28'h000_0000, irq});
    wr(`QTU_POL_OFS, 32'h0000_0001);
    wr(`QTU_MODE_OFS, 32'h0000_0004);
    wr(`QTU_PEND_OFS, 32'h0000_000F);
    repeat (3) @(posedge clk);
    check("stopped pins", 32'h0000_0001, {30'h0000_0000, timer_io_pin[1:0]});
    check("irq clear", 32'h0000_0000, {28'h000_0000, irq});
    rd(`QTU_CNT_OFS);
    s_axi_wdata <= rdat;
    repeat (20) @(posedge clk);
    rd(`QTU_CNT_OFS);
    check("frozen count", s_axi_wdata, rdat);
    wr(`QTU_POL_OFS, 32'h0000_0000);
    wr(`QTU_CNT_OFS, 32'h0000_0033);
    rd(`QTU_CNT_OFS);
    check("preset", 32'h0000_0033, rdat);
    wr(`QTU_PRSC_OFS, 32'h0000_00FF);
    wr(`QTU_MODE_OFS, 32'h0000_0006);
    wr(`QTU_CNT_OFS, 32'h0000_00AA);
    rd(`QTU_CNT_OFS);
    check("write while running", 32'h0000_0033, {24'h00_0000, rdat[7:0]});
    wr(`QTU_PER_OFS, 32'h0000_1234);
    rd(`QTU_PER_OFS);
    check("pending period", 32'h0000_1234, rdat);
    wr(`QTU_MODE_OFS, 32'h0000_0004);
    wr(`QTU_PRSC_OFS, 32'h0000_0000);
    wr(`QTU_PER_OFS, 32'h0000_0002);
    wr(`QTU_DTY_OFS, 32'h0000_0001);
    wr(`QTU_CNT_OFS, 32'h0000_0080);
    tally_clear();
    wr(`QTU_MODE_OFS, 32'h0000_0005);
    repeat (100) @(posedge clk);
    check("no early rise", 32'h0000_0000, {16'h0000, rs[0]});
    repeat (60) @(posedge clk);
    check("rise after roll", 32'h0000_0001, {31'h0000_0000, rs[0] != 16'h0000});
    wr(`QTU_MODE_OFS, `QTU_RST_WORD);
    wr(`QTU_PER_OFS, 32'h0000_0055);
    rd(`QTU_PER_OFS);
    check("low power write", 32'h0000_0002, rdat);
    wr(8'hFC, 32'h0000_0001);
    check("unmapped write", {30'h0000_0000, `QTU_RESP_DECERR}, {30'h0000_0000, rsp});
    rd(8'hFC);
    check("unmapped read", {30'h0000_0000, `QTU_RESP_DECERR}, {30'h0000_0000, rsp});
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`QTU_PER_OFS);
    check("period reset", `QTU_RST_WORD, rdat);
    check("pins reset", 32'h0000_0000, {24'h00_0000, timer_io_pin});
    print_verdict();
  end
endmodule // qtu_top_tb_top
